// ===== src/pmc_phy_mode_regs.sv
`timescale 1ns/1ps
`include "pmc_params.svh"

// Overview of operation
// [R1] Soft-reset bit resets the physical-layer logic; clock output logic keeps running.
// [R2] Soft-reset bit clears itself 32 byte times after being set.
// [R3] Software can only set the soft-reset bit; writing zero does nothing.
// [R4] Writes to the mode register at 1Eh are ignored during reset.
// [R5] Parity enable off skips checks; on checks every control-bus write.
// [R6] Parity mismatch on checked write flags error and drops the access.
// [R7] Read data always carries generated parity.
// [R8] Rate select resets to slow clock output; one selects the fast rate.
// [R9] Rate change switches the output clock without glitch or runt.
// [R10] Trigger with scrub enable loads configuration image and starts scrubbing changed ports.
// [R11] Scrub sends two invalid symbols, then pairs until the timer ends.
// [R12] Reading the history register copies it into the shadow at 1Fh.
// [R13] History bits differing from shadow keep value; inhibit flag is raised.
// [R14] Shadow holds expired compare at D6, trigger compare at D7; rest reserved.
// [R15] Any history bit set with its mask bit raises the connection service event.
// [R16] Scrub timer expiry sets the expired bit D6 of history at 20h.
// [R17] Expired bit set protects the path configuration register.
// [R18] Trigger sets trigger bit D7 and loads trigger transmit mode bits.
// [R19] Trigger bit set protects the transmit state register.
// [R20] Mask register at 21h: trigger mask D7, expired mask D6, rest reserved.
// [R21] Scrub timer counts down 8-bit threshold in 40.96 us steps.
// [R22] Upper five trigger definition bits enable events; lower three give mode.
// [R23] History bits stay set until a checked software write clears them; here an unchecked write with parity off or a soft reset also clears them.
module pmc_phy_mode_regs import pmc_pkg::*; #(
  parameter int PORTS       = 2,
  parameter int STEP_CYCLES = `PMC_SCRUB_STEP_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire pmc_cbus_req_t    cbReq,
  input  wire logic [4:0]       trigEvents,
  input  wire logic [PORTS-1:0] portChanged,
  input  wire logic             symbolTick,
  output pmc_cbus_rsp_t         cbRsp,
  output pmc_icr_evt_t          icrEvt,
  output logic                  phySoftReset,
  output logic                  connServiceEvent,
  output logic                  cfgProtect,
  output logic                  txStateProtect,
  output logic                  txModeLoad,
  output logic [2:0]            txModeValue,
  output logic                  loadConfigImage,
  output logic [PORTS-1:0]      scrubPorts,
  output logic                  sendInvalid,
  output logic                  sendScrubPairs,
  output logic                  sysClkOut
);

  localparam int RstCyc  = `PMC_SOFT_RST_CYC;
  localparam int RstHold = `PMC_SOFT_RST_CYC - 1;

  logic       parEn;
  logic       rateSel;
  logic       scrubEn;
  logic [7:0] rstCount;
  logic [7:0] hist;
  logic [7:0] shadow;
  logic [7:0] mask;
  logic [7:0] threshold;
  logic [7:0] trigDef;
  logic [7:0] next_hist;
  logic [7:0] timerValue;
  logic       scrubExpired;

  // ==========================================================================
  // Control-bus decode.
  wire logic       parityGood = ^{cbReq.data, cbReq.parity};
  wire logic       parFail    = cbReq.wr && parEn && !parityGood;              // [R6]
  wire logic       wrOk       = cbReq.wr && (!parEn || parityGood);            // [R5]
  wire logic       hitCfg2    = (cbReq.addr == `PMC_ADDR_CFG2);
  wire logic       hitShadow  = (cbReq.addr == `PMC_ADDR_SHADOW);
  wire logic       hitHist    = (cbReq.addr == `PMC_ADDR_HIST);
  wire logic       hitMask    = (cbReq.addr == `PMC_ADDR_MASK);
  wire logic       hitThresh  = (cbReq.addr == `PMC_ADDR_STHRESH);
  wire logic       hitValue   = (cbReq.addr == `PMC_ADDR_SVALUE);
  wire logic       hitTrigDef = (cbReq.addr == `PMC_ADDR_TRIGDEF);
  wire logic       wrCfg2     = wrOk && hitCfg2 && !phySoftReset;              // [R4]
  wire logic       wrShadow   = wrOk && hitShadow;
  wire logic       wrHist     = wrOk && hitHist;
  wire logic       wrMask     = wrOk && hitMask;
  wire logic       wrThresh   = wrOk && hitThresh;
  wire logic       wrTrigDef  = wrOk && hitTrigDef;
  wire logic       rdHist     = cbReq.rd && hitHist;
  wire logic       rstDone    = (rstCount == 8'(RstCyc - 1));

  // ==========================================================================
  // Trigger and history logic.
  wire logic [4:0] trigSel  = trigDef[`PMC_TRIG_SEL_HI:`PMC_TRIG_SEL_LO];
  wire logic [2:0] trigMode = trigDef[`PMC_TRIG_MODE_HI:`PMC_TRIG_MODE_LO];
  wire logic       trigHit  = !phySoftReset && |(trigEvents & trigSel);        // [R22]
  wire logic       scrubGo  = trigHit && scrubEn;                              // [R10]
  wire logic [7:0] histDiff = (hist ^ shadow) & `PMC_HIST_BITS;
  wire logic [7:0] histFree = ~histDiff & `PMC_HIST_BITS;
  wire logic       cwiHit   = wrHist && (histDiff != `PMC_ZERO8);              // [R13]
  wire logic [7:0] histWr   = (hist & ~histFree) | (cbReq.data & histFree);    // [R13] [R23]
  wire logic [7:0] histBase = wrHist ? histWr : hist;
  wire logic [7:0] histSet  = {trigHit, scrubExpired, 6'h00};                  // [R16] [R18]

  // Hardware events are ORed after the write, so a set wins over a clear.
  always_comb begin
    next_hist = (histBase | histSet) & `PMC_HIST_BITS;
    if (phySoftReset) next_hist = `PMC_ZERO8;                                 // [R1]
  end

  // ==========================================================================
  // Read data; reserved bits and unmapped offsets read as zero.
  wire logic [7:0] cfg2Read = {scrubEn, 1'b0, rateSel, 3'b000, parEn, phySoftReset};
  wire logic [7:0] rdMux    = hitCfg2    ? cfg2Read  :
                              hitShadow  ? shadow    :
                              hitHist    ? hist      :
                              hitMask    ? mask      :
                              hitThresh  ? threshold :
                              hitValue   ? timerValue :
                              hitTrigDef ? trigDef   : `PMC_ZERO8;

  // ==========================================================================
  // Mode register two and soft reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phySoftReset <= 1'b0;
      rstCount     <= `PMC_ZERO8;
      parEn        <= 1'b0;
      rateSel      <= 1'b0;                                                   // [R8]
      scrubEn      <= 1'b0;
    end else begin
      if (wrCfg2) begin
        parEn   <= cbReq.data[`PMC_CFG2_PAREN];
        rateSel <= cbReq.data[`PMC_CFG2_RATE];                                // [R8]
        scrubEn <= cbReq.data[`PMC_CFG2_SCRUBEN];
        if (cbReq.data[`PMC_CFG2_RST]) phySoftReset <= 1'b1;                  // [R3]
      end
      if (phySoftReset) begin
        rstCount <= rstDone ? `PMC_ZERO8 : rstCount + 8'h01;
        if (rstDone) phySoftReset <= 1'b0;                                    // [R2]
      end
    end
  end

  // ==========================================================================
  // Condition registers, cleared by either reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hist      <= `PMC_ZERO8;
      shadow    <= `PMC_ZERO8;
      mask      <= `PMC_ZERO8;
      threshold <= `PMC_ZERO8;
      trigDef   <= `PMC_ZERO8;
    end else begin
      hist <= next_hist;
      if (phySoftReset) begin                                                 // [R1]
        shadow    <= `PMC_ZERO8;
        mask      <= `PMC_ZERO8;
        threshold <= `PMC_ZERO8;
        trigDef   <= `PMC_ZERO8;
      end else begin
        if (rdHist) shadow <= hist;                                           // [R12]
        else if (wrShadow) shadow <= cbReq.data & `PMC_HIST_BITS;             // [R14]
        if (wrMask) mask <= cbReq.data & `PMC_HIST_BITS;                      // [R20]
        if (wrThresh) threshold <= cbReq.data;
        if (wrTrigDef) trigDef <= cbReq.data;
      end
    end
  end

  // ==========================================================================
  // Registered outputs toward the bus, the flag register and the data path.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cbRsp            <= '0;
      icrEvt           <= '0;
      connServiceEvent <= 1'b0;
      cfgProtect       <= 1'b0;
      txStateProtect   <= 1'b0;
      txModeLoad       <= 1'b0;
      txModeValue      <= 3'b000;
      loadConfigImage  <= 1'b0;
      scrubPorts       <= '0;
    end else begin
      if (cbReq.rd) begin
        cbRsp.data   <= rdMux;
        cbRsp.parity <= ~^rdMux;                                              // [R7]
      end
      icrEvt.parityErr        <= parFail;                                     // [R6]
      icrEvt.condWriteInhibit <= cwiHit;                                      // [R13]
      icrEvt.writeReject      <= wrOk && hitValue;
      connServiceEvent <= |(hist & mask);                                     // [R15]
      cfgProtect       <= next_hist[`PMC_HIST_STE];                           // [R17]
      txStateProtect   <= next_hist[`PMC_HIST_TCO];                           // [R19]
      txModeLoad       <= trigHit;                                            // [R18]
      if (trigHit) txModeValue <= trigMode;                                   // [R18]
      loadConfigImage  <= scrubGo;                                            // [R10]
      if (phySoftReset) scrubPorts <= '0;
      else if (scrubGo) scrubPorts <= portChanged;                            // [R10]
    end
  end

  // ==========================================================================
  // Submodules. The clock output is kept out of the soft reset on purpose.
  pmc_scrub_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_scrub (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .abort       (phySoftReset),
    .start       (scrubGo),                                                   // [R10]
    .threshold   (threshold),
    .symbolTick  (symbolTick),
    .sendInvalid (sendInvalid),                                               // [R11]
    .sendPairs   (sendScrubPairs),
    .expired     (scrubExpired),
    .timerValue  (timerValue)
  );

  pmc_clk_out_gen u_clk (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),                                                     // [R1]
    .rateSel   (rateSel),
    .sysClkOut (sysClkOut)
  );

  // ==========================================================================
  // Checks.
  a_softrst_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(phySoftReset) |-> ##RstCyc !phySoftReset) // [R2]
    else $error("Soft reset did not clear on time.");

  a_softrst_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(phySoftReset) |-> ##RstHold phySoftReset) // [R3]
    else $error("Soft reset cleared early.");

  a_cfg2_frozen: assert property (@(posedge sys_clk) disable iff (sys_rst)
    phySoftReset |=> $stable({scrubEn, rateSel, parEn})) // [R4]
    else $error("Mode register changed during reset.");

  a_parity_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cbReq.wr && parEn && !parityGood && hitMask |=> icrEvt.parityErr && $stable(mask)) // [R6]
    else $error("Bad-parity write was not discarded and flagged.");

  a_read_parity: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cbReq.rd |=> ^{cbRsp.data, cbRsp.parity}) // [R7]
    else $error("Read data parity is not odd.");

  a_shadow_copy: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rdHist && !phySoftReset |=> shadow == $past(hist)) // [R12]
    else $error("Shadow did not capture history on read.");

  a_inhibit_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wrHist && (histDiff != `PMC_ZERO8) && !phySoftReset && (histSet == `PMC_ZERO8)
      |=> icrEvt.condWriteInhibit
          && ((hist & $past(histDiff)) == ($past(hist) & $past(histDiff)))) // [R13]
    else $error("Mismatching history bit changed or inhibit not flagged.");

  a_service_event: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hist & mask) != `PMC_ZERO8 |=> connServiceEvent) // [R15]
    else $error("Connection service event missing.");

  a_trigger_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    trigHit |=> txModeLoad && txStateProtect && txModeValue == $past(trigMode)) // [R18]
    else $error("Trigger did not load transmit mode.");

  a_expired_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
    scrubExpired && !phySoftReset |=> hist[`PMC_HIST_STE] && cfgProtect) // [R16]
    else $error("Scrub expiry did not set history bit.");

endmodule // pmc_phy_mode_regs

// ===== src/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// ==========================================================================
// Register offsets on the control bus.
`define PMC_ADDR_CFG2      6'h1e
`define PMC_ADDR_SHADOW    6'h1f
`define PMC_ADDR_HIST      6'h20
`define PMC_ADDR_MASK      6'h21
`define PMC_ADDR_STHRESH   6'h24
`define PMC_ADDR_SVALUE    6'h25
`define PMC_ADDR_TRIGDEF   6'h26

// ==========================================================================
// Field positions.
`define PMC_CFG2_RST       0
`define PMC_CFG2_PAREN     1
`define PMC_CFG2_RATE      5
`define PMC_CFG2_SCRUBEN   7
`define PMC_HIST_STE       6
`define PMC_HIST_TCO       7
`define PMC_HIST_BITS      8'hc0
`define PMC_TRIG_SEL_HI    7
`define PMC_TRIG_SEL_LO    3
`define PMC_TRIG_MODE_HI   2
`define PMC_TRIG_MODE_LO   0

// ==========================================================================
// Reset values.
`define PMC_ZERO8          8'h00

// ==========================================================================
// Timing, in picoseconds, and derived cycle counts (least times round up).
`define PMC_CLK_PERIOD_PS  25000
`define PMC_BYTE_TIME_PS   80000
`define PMC_SOFT_RST_BYTES 32
`define PMC_SOFT_RST_CYC   ((`PMC_SOFT_RST_BYTES * `PMC_BYTE_TIME_PS + `PMC_CLK_PERIOD_PS - 1) / `PMC_CLK_PERIOD_PS)
`define PMC_SCRUB_STEP_PS  40960000
`define PMC_SCRUB_STEP_CYC ((`PMC_SCRUB_STEP_PS + `PMC_CLK_PERIOD_PS - 1) / `PMC_CLK_PERIOD_PS)
`define PMC_INVALID_SYMS   2

// ==========================================================================
// Output clock phase increments: rate = 40 MHz * inc / 64.
`define PMC_INC_SLOW       6'h19
`define PMC_INC_FAST       6'h32

`endif

// ===== src/pmc_pkg.sv
package pmc_pkg;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] data;
    logic       parity;
  } pmc_cbus_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
  } pmc_cbus_rsp_t;

  typedef struct packed {
    logic parityErr;
    logic condWriteInhibit;
    logic writeReject;
  } pmc_icr_evt_t;

  typedef enum logic [2:0] {
    PMC_SCR_IDLE    = 3'b001,
    PMC_SCR_INVALID = 3'b010,
    PMC_SCR_PAIRS   = 3'b100
  } pmc_scrub_state_t;

endpackage

// ===== src/pmc_clk_out_gen.sv
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_clk_out_gen import pmc_pkg::*; (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic rateSel,
  output logic      sysClkOut
);

  logic [5:0] phaseAcc;
  logic [5:0] curInc;
  logic [6:0] sum;

  assign sum = {1'b0, phaseAcc} + {1'b0, curInc};

  // ========================================================================
  // Rate changes only at a phase wrap, so no shortened high phase appears.
  // Limitation: from a 40 MHz base the output is a rate-averaged clock.
  // The output is high for one cycle per phase wrap. The accumulator's top bit would
  // alias at the fast rate, because the fast increment exceeds half the phase range.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phaseAcc  <= 6'h00;
      curInc    <= `PMC_INC_SLOW;
      sysClkOut <= 1'b0;
    end else begin
      phaseAcc  <= sum[5:0];
      sysClkOut <= sum[6];
      if (sum[6]) begin
        curInc <= rateSel ? `PMC_INC_FAST : `PMC_INC_SLOW; // [R8] [R9]
      end
    end
  end

  a_rate_wrap_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$past(sum[6]) |-> $stable(curInc)) // [R9]
    else $error("Output clock increment changed away from a phase wrap.");

endmodule // pmc_clk_out_gen

// ===== src/pmc_scrub_timer.sv
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_scrub_timer import pmc_pkg::*; #(
  parameter int STEP_CYCLES = `PMC_SCRUB_STEP_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       abort,
  input  wire logic       start,
  input  wire logic [7:0] threshold,
  input  wire logic       symbolTick,
  output logic            sendInvalid,
  output logic            sendPairs,
  output logic            expired,
  output logic [7:0]      timerValue
);

  pmc_scrub_state_t state;
  pmc_scrub_state_t next_state;
  logic [1:0]       invCount;
  logic [11:0]      preCount;
  logic             stepDone;
  logic             invDone;
  logic             timeUp;

  assign stepDone = (preCount == 12'(STEP_CYCLES - 1));
  assign invDone  = symbolTick && (invCount == 2'(`PMC_INVALID_SYMS - 1));
  assign timeUp   = stepDone && (timerValue == `PMC_ZERO8);

  always_comb begin
    next_state = state;
    case (state)
      PMC_SCR_IDLE:    if (start) next_state = PMC_SCR_INVALID;
      PMC_SCR_INVALID: if (invDone) next_state = PMC_SCR_PAIRS; // [R11]
      PMC_SCR_PAIRS:   if (timeUp) next_state = PMC_SCR_IDLE;
      default:         next_state = PMC_SCR_IDLE;
    endcase
    if (start) next_state = PMC_SCR_INVALID;
    if (abort) next_state = PMC_SCR_IDLE;
  end

  // ========================================================================
  // The threshold is latched at start; later writes leave this run alone.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state       <= PMC_SCR_IDLE;
      invCount    <= 2'h0;
      preCount    <= 12'h000;
      timerValue  <= `PMC_ZERO8;
      sendInvalid <= 1'b0;
      sendPairs   <= 1'b0;
      expired     <= 1'b0;
    end else begin
      state       <= next_state;
      sendInvalid <= (next_state == PMC_SCR_INVALID);
      sendPairs   <= (next_state == PMC_SCR_PAIRS);
      expired     <= !abort && !start && (state == PMC_SCR_PAIRS) && timeUp; // [R21]
      if (start || state != PMC_SCR_PAIRS) preCount <= 12'h000;
      else preCount <= stepDone ? 12'h000 : preCount + 12'h001;
      if (start) timerValue <= threshold;
      else if (state == PMC_SCR_PAIRS && stepDone && !timeUp)
        timerValue <= timerValue - 8'h01; // [R21]
      if (state != PMC_SCR_INVALID || start) invCount <= 2'h0;
      else if (symbolTick) invCount <= invCount + 2'h1;
    end
  end

  a_invalid_then_pairs: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == PMC_SCR_INVALID) && invDone && !start && !abort |=> sendPairs) // [R11]
    else $error("Scrub did not move to symbol pairs after two invalid symbols.");

endmodule // pmc_scrub_timer

// ===== dv/pmc_cbus_master.sv
`timescale 1ns/1ps
// ==========================================================================
// Control-bus master model.
module pmc_cbus_master import pmc_pkg::*; (
  input  wire logic    sys_clk,
  output pmc_cbus_req_t cbReq
);
  initial cbReq = '0;

  // One strobe per access; the data lines are inverted after release so that a
  // design that samples late sees wrong data instead of a lucky match.
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] data,
                        input logic badPar);
    @(posedge sys_clk);
    cbReq <= '{rd: ~wr, wr: wr, addr: addr, data: data, parity: ~^data ^ badPar};
    @(posedge sys_clk);
    cbReq.rd   <= 1'b0;
    cbReq.wr   <= 1'b0;
    cbReq.data <= ~data;
  endtask
endmodule // pmc_cbus_master

// ===== dv/phy_mode_and_cmt_condition_regs_tb.sv
`timescale 1ns/1ps
module phy_mode_and_cmt_condition_regs_tb import pmc_pkg::*;;
  logic sys_clk, sys_rst, symbolTick, phySoftReset, connServiceEvent, cfgProtect;
  logic txStateProtect, txModeLoad, loadConfigImage, sendInvalid, sendScrubPairs, sysClkOut;
  pmc_cbus_req_t cbReq;
  pmc_cbus_rsp_t cbRsp;
  pmc_icr_evt_t  icrEvt, evt;
  logic [4:0]    trigEvents;
  logic [1:0]    portChanged, scrubPorts, pc;
  logic [2:0]    txModeValue, mode;
  logic [7:0]    d, hist, shadow, cnt;
  int            failures, n_checks, seed, n, k;
  logic [5:0]    rstAddr [5] = '{6'h1e, 6'h1f, 6'h20, 6'h21, 6'h3f};

  pmc_cbus_master i_pmc_cbus_master (.sys_clk(sys_clk), .cbReq(cbReq));
  pmc_phy_mode_regs #(.PORTS(2), .STEP_CYCLES(4)) i_pmc_phy_mode_regs (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cbReq(cbReq), .trigEvents(trigEvents),
    .portChanged(portChanged), .symbolTick(symbolTick), .cbRsp(cbRsp), .icrEvt(icrEvt),
    .phySoftReset(phySoftReset), .connServiceEvent(connServiceEvent),
    .cfgProtect(cfgProtect), .txStateProtect(txStateProtect), .txModeLoad(txModeLoad),
    .txModeValue(txModeValue), .loadConfigImage(loadConfigImage), .scrubPorts(scrubPorts),
    .sendInvalid(sendInvalid), .sendScrubPairs(sendScrubPairs), .sysClkOut(sysClkOut));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Checking and bus helpers.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic bad);
    i_pmc_cbus_master.access(1'b1, a, v, bad);
    #1 evt = icrEvt;
  endtask
  task automatic rd(input logic [5:0] a);
    i_pmc_cbus_master.access(1'b0, a, 8'h00, 1'b0);
    #1 d = cbRsp.data;
    chk1("read parity", ~^cbRsp.data, cbRsp.parity);
  endtask
  task automatic cnt_clk(input int cyc, output logic [7:0] c);
    c = 8'h00;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1;
      if (sysClkOut === 1'b1) c++;
    end
  endtask
  // Bits whose history and shadow copies agree take the written value.
  function automatic logic [7:0] histWrite(input logic [7:0] h, s, v);
    logic [7:0] same;
    same = ~(h ^ s) & 8'hc0;
    return (h & ~same) | (v & same);
  endfunction

  // ==========================================================================
  // Main sequence.
  initial begin
    seed = 32'hcde04fdc;
    sys_rst = 1'b1;
    trigEvents = 5'h00;
    portChanged = 2'b00;
    symbolTick = 1'b0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rstAddr[i]) begin
      rd(rstAddr[i]);
      chk8("reset value", 8'h00, d);
    end
    $display("done: reset values");
    cnt_clk(128, cnt);
    chk8("slow clock edges", 8'd50, cnt);
    wr(6'h1e, 8'h20, 1'b0);
    repeat (64) @(posedge sys_clk);
    cnt_clk(128, cnt);
    chk8("fast clock edges", 8'd100, cnt);
    $display("done: clock rate");
    wr(6'h21, 8'h80, 1'b1);
    chk1("parity error off", 1'b0, evt.parityErr);
    mode = 3'($random(seed));
    pc = 2'($random(seed)) | 2'b01;
    wr(6'h26, {5'b00001, mode}, 1'b0);
    wr(6'h24, 8'h01, 1'b0);
    wr(6'h1e, 8'ha0, 1'b0);
    portChanged <= pc;
    @(posedge sys_clk);
    trigEvents <= 5'h01;
    @(posedge sys_clk);
    trigEvents <= 5'h00;
    #1;
    chk1("mode load", 1'b1, txModeLoad);
    chk8("mode value", {5'h00, mode}, {5'h00, txModeValue});
    chk1("config image load", 1'b1, loadConfigImage);
    chk8("scrub ports", {6'h00, pc}, {6'h00, scrubPorts});
    chk1("send invalid", 1'b1, sendInvalid);
    @(posedge sys_clk);
    #1;
    chk1("tx state protect", 1'b1, txStateProtect);
    chk1("service event", 1'b1, connServiceEvent);
    hist = 8'h80;
    rd(6'h20);
    chk8("history", hist, d);
    shadow = hist;
    rd(6'h1f);
    chk8("shadow", shadow, d);
    repeat (2) begin
      @(posedge sys_clk);
      symbolTick <= 1'b1;
      @(posedge sys_clk);
      symbolTick <= 1'b0;
    end
    #1;
    chk1("scrub pairs", 1'b1, sendScrubPairs);
    for (n = 0; n < 40 && cfgProtect !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 40) begin
      failures++;
      stop_test();
    end
    chk1("scrub length", 1'b1, n >= 7 && n <= 12);
    chk1("pairs stop", 1'b0, sendScrubPairs);
    hist = 8'hc0;
    $display("done: trigger and scrub");
    wr(6'h20, 8'h00, 1'b0);
    chk1("write inhibit", 1'b1, evt.condWriteInhibit);
    hist = histWrite(hist, shadow, 8'h00);
    @(posedge sys_clk);
    #1;
    chk1("tx state released", 1'b0, txStateProtect);
    chk1("config still protected", 1'b1, cfgProtect);
    rd(6'h20);
    chk8("history kept", hist, d);
    shadow = hist;
    wr(6'h20, 8'h00, 1'b0);
    chk1("no inhibit", 1'b0, evt.condWriteInhibit);
    hist = histWrite(hist, shadow, 8'h00);
    @(posedge sys_clk);
    #1;
    chk1("config released", 1'b0, cfgProtect);
    chk1("service event off", 1'b0, connServiceEvent);
    rd(6'h20);
    chk8("history cleared", hist, d);
    $display("done: read before write");
    wr(6'h1e, 8'ha2, 1'b0);
    wr(6'h21, 8'h40, 1'b1);
    chk1("parity error", 1'b1, evt.parityErr);
    rd(6'h21);
    chk8("discarded write", 8'h80, d);
    wr(6'h21, 8'h40, 1'b0);
    chk1("good parity", 1'b0, evt.parityErr);
    wr(6'h25, 8'h55, 1'b0);
    chk1("timer value write reject", 1'b1, evt.writeReject);
    $display("done: parity");
    wr(6'h1e, 8'ha3, 1'b0);
    chk1("soft reset", 1'b1, phySoftReset);
    n = 1;
    wr(6'h1e, 8'h00, 1'b0);
    n += 2;
    for (k = 0; k < 200 && phySoftReset === 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
      if (phySoftReset === 1'b1) n++;
    end
    chk8("soft reset cycles", 8'd103, n[7:0]);
    rd(6'h1e);
    chk8("mode after reset", 8'ha2, d);
    rd(6'h21);
    chk8("mask after reset", 8'h00, d);
    $display("done: soft reset");
    stop_test();
  end
endmodule // phy_mode_and_cmt_condition_regs_tb
